// ==== verilog/smcs_defs.vh ====
`ifndef SMCS_DEFS_VH
`define SMCS_DEFS_VH

// ==========================================================
// slave address
`define SMCS_ADDR_BASE 7'h50
`define SMCS_ADDR_STRAP_LSB 1
`define SMCS_ADDR_STRAP_MSB 4

// ==========================================================
// register offsets
`define SMCS_OFS_SOFT_RESET 8'h00
`define SMCS_OFS_LANE_PDN 8'h01
`define SMCS_OFS_PDN_GATE 8'h02
`define SMCS_OFS_PATH_SEL 8'h03
`define SMCS_OFS_PIN_OVR 8'h08

// ==========================================================
// reset values
`define SMCS_RST_SOFT_RESET 8'h00
`define SMCS_RST_LANE_PDN 8'h00
`define SMCS_RST_PDN_GATE 8'h00
`define SMCS_RST_PATH_SEL 8'h00
`define SMCS_RST_PIN_OVR 8'h00

// ==========================================================
// field positions
`define SMCS_BIT_SOFT_RESET 0
`define SMCS_BIT_PDN_ENABLE 0
`define SMCS_BIT_LANE_ONE_SIDE_PICK 2
`define SMCS_BIT_LANE_ZERO_SIDE_PICK 1
`define SMCS_BIT_DUAL_OUTPUT_BROADCAST 0
`define SMCS_BIT_OVR_IDLE 4
`define SMCS_BIT_OVR_RATE 2
`define SMCS_BIT_OVR_SEL 1
`define SMCS_BIT_OVR_DUAL_OUTPUT_BROADCAST 0
`define SMCS_BIT_PDN_LANE_ZERO_A_OUTPUT 4
`define SMCS_BIT_PDN_LANE_ZERO_B_OUTPUT 5
`define SMCS_BIT_PDN_LANE_ONE_A_OUTPUT 6
`define SMCS_BIT_PDN_SOB1 7

// ==========================================================
// timing
`define SMCS_CLK_NS 50
`define SMCS_T_BUF_NS 4700
`define SMCS_T_HIGH_MAX_NS 50000
`define SMCS_T_BUF_CYC ((`SMCS_T_BUF_NS + `SMCS_CLK_NS - 1) / `SMCS_CLK_NS)
`define SMCS_T_HIGH_CYC (`SMCS_T_HIGH_MAX_NS / `SMCS_CLK_NS)

`endif

// ==== verilog/smcs_pin_sync.v ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// three-stage pin synchroniser; the output moves only when the
// second and third stages agree, which rejects single-sample glitches
module smcs_pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire reset_n,
    input wire [WIDTH-1:0] pin,
    output reg [WIDTH-1:0] level
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;
integer i;

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        stage1 <= RESET_VAL;
        stage2 <= RESET_VAL;
        stage3 <= RESET_VAL;
        level <= RESET_VAL;
    end
    else
    begin
        stage1 <= pin;
        stage2 <= stage1;
        stage3 <= stage2;
        for (i = 0; i < WIDTH; i = i + 1)
        begin
            if (stage2[i] == stage3[i])
            begin
                level[i] <= stage3[i];
            end
        end
    end
end

endmodule

`default_nettype wire

// ==== verilog/smcs_config_slave.v ====
`timescale 1ns/1ps
`default_nettype none
`include "smcs_defs.vh"

module smcs_config_slave (
    input wire clk,
    input wire reset_n,
    input wire serial_mgmt_mode_pin,
    input wire serial_mgmt_clock,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire [3:0] addr_strap,
    input wire pin_lane_zero_side_pick,
    input wire pin_lane_one_side_pick,
    input wire pin_dual_output_broadcast,
    output reg bus_idle,
    output reg [7:0] lane_sleep,
    output reg lane_zero_side_pick,
    output reg lane_one_side_pick,
    output reg dual_output_broadcast,
    output reg lane_zero_a_output_mute,
    output reg lane_zero_b_output_mute,
    output reg lane_one_a_output_mute,
    output reg lane_one_b_output_mute,
    output reg idle_pin_blocked,
    output reg rate_pin_blocked
);

// ==========================================================
// input synchronisers
localparam ST_IDLE = 2'h0;
localparam ST_RX = 2'h1;
localparam ST_ACK = 2'h2;
localparam ST_TX = 2'h3;
localparam PH_ADDR = 2'h0;
localparam PH_REG = 2'h1;
localparam PH_DATA = 2'h2;
localparam PH_DROP = 2'h3;

wire scl_s;
wire sda_s;
wire [7:0] misc_s;

smcs_pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_scl_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin(serial_mgmt_clock),
    .level(scl_s)
);

smcs_pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sda_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin(sda_in),
    .level(sda_s)
);

smcs_pin_sync #(.WIDTH(8), .RESET_VAL(8'h00)) u_misc_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin({pin_dual_output_broadcast, pin_lane_one_side_pick, pin_lane_zero_side_pick,
          serial_mgmt_mode_pin, addr_strap}),
    .level(misc_s)
);

wire [3:0] strap_s = misc_s[3:0];
wire mode_s = misc_s[4];
wire lane_zero_side_pick_pin_s = misc_s[5];
wire lane_one_side_pick_pin_s = misc_s[6];
wire fan_pin_s = misc_s[7];

// ==========================================================
// line conditions
reg scl_q;
reg sda_q;
wire scl_rise = scl_s & ~scl_q;
wire scl_fall = ~scl_s & scl_q;
// relies on the host holding data steady while the clock is high
wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;

wire [6:0] addr_base = `SMCS_ADDR_BASE;
// straps sit on address-byte bits [4:1], which are the low four address bits
wire [7:0] strap_byte = {3'h0, strap_s, 1'b0};
wire [6:0] my_addr = addr_base | {3'h0, strap_byte[`SMCS_ADDR_STRAP_MSB:`SMCS_ADDR_STRAP_LSB]};

// ==========================================================
// idle detection
reg [10:0] idle_cnt;
reg after_stop;

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        scl_q <= 1'b1;
        sda_q <= 1'b1;
        idle_cnt <= 11'h000;
        after_stop <= 1'b0;
        bus_idle <= 1'b1;
    end
    else
    begin
        scl_q <= scl_s;
        sda_q <= sda_s;
        if (stop_cond)
        begin
            after_stop <= 1'b1;
        end
        else if (start_cond)
        begin
            after_stop <= 1'b0;
        end
        if (start_cond)
        begin
            bus_idle <= 1'b0;
        end
        if (scl_s && sda_s)
        begin
            if (idle_cnt != 11'h7FF)
            begin
                idle_cnt <= idle_cnt + 11'h001;
            end
            if ((after_stop && idle_cnt >= `SMCS_T_BUF_CYC) ||
                idle_cnt >= `SMCS_T_HIGH_CYC)
            begin
                bus_idle <= 1'b1;
            end
        end
        else
        begin
            idle_cnt <= 11'h000;
        end
    end
end

// ==========================================================
// protocol engine and register bank
reg [1:0] state;
reg [1:0] phase;
reg [3:0] bit_cnt;
reg [7:0] shreg;
reg rd_mode;
reg [7:0] reg_ptr;
reg [7:0] soft_reset_ctrl;
reg [7:0] lane_power_down;
reg [7:0] power_down_gate;
reg [7:0] path_select_broadcast;
reg [7:0] pin_override_ctrl;
reg [7:0] rd_data;

always @*
begin
    case (reg_ptr)
        `SMCS_OFS_SOFT_RESET: rd_data = soft_reset_ctrl;
        `SMCS_OFS_LANE_PDN: rd_data = lane_power_down;
        `SMCS_OFS_PDN_GATE: rd_data = power_down_gate;
        `SMCS_OFS_PATH_SEL: rd_data = path_select_broadcast;
        `SMCS_OFS_PIN_OVR: rd_data = pin_override_ctrl;
        default: rd_data = 8'h00;
    endcase
end

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        state <= ST_IDLE;
        phase <= PH_ADDR;
        bit_cnt <= 4'h0;
        shreg <= 8'h00;
        rd_mode <= 1'b0;
        reg_ptr <= 8'h00;
        sda_out <= 1'b0;
        sda_oe <= 1'b0;
        soft_reset_ctrl <= `SMCS_RST_SOFT_RESET;
        lane_power_down <= `SMCS_RST_LANE_PDN;
        power_down_gate <= `SMCS_RST_PDN_GATE;
        path_select_broadcast <= `SMCS_RST_PATH_SEL;
        pin_override_ctrl <= `SMCS_RST_PIN_OVR;
    end
    else if (!mode_s)
    begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
    end
    else if (stop_cond || (bus_idle && !start_cond))
    begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
    end
    else if (start_cond)
    begin
        state <= ST_RX;
        phase <= PH_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
    end
    else
    begin
        case (state)
            ST_RX:
            begin
                if (scl_rise && bit_cnt != 4'h8)
                begin
                    shreg <= {shreg[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                else if (scl_fall && bit_cnt == 4'h8 && phase != PH_DROP)
                begin
                    bit_cnt <= 4'h0;
                    state <= ST_ACK;
                    sda_oe <= 1'b1;
                    case (phase)
                        PH_ADDR:
                        begin
                            rd_mode <= shreg[0];
                            if (shreg[7:1] != my_addr)
                            begin
                                sda_oe <= 1'b0;
                                state <= ST_RX;
                                phase <= PH_DROP;
                            end
                        end
                        PH_REG: reg_ptr <= shreg;
                        default:
                        begin
                            if (reg_ptr == `SMCS_OFS_SOFT_RESET &&
                                shreg[`SMCS_BIT_SOFT_RESET])
                            begin
                                // the reset bit itself is cleared too, so it reads 0
                                soft_reset_ctrl <= `SMCS_RST_SOFT_RESET;
                                lane_power_down <= `SMCS_RST_LANE_PDN;
                                power_down_gate <= `SMCS_RST_PDN_GATE;
                                path_select_broadcast <= `SMCS_RST_PATH_SEL;
                                pin_override_ctrl <= `SMCS_RST_PIN_OVR;
                            end
                            else
                            begin
                                case (reg_ptr)
                                    `SMCS_OFS_SOFT_RESET: soft_reset_ctrl <= shreg;
                                    `SMCS_OFS_LANE_PDN: lane_power_down <= shreg;
                                    `SMCS_OFS_PDN_GATE: power_down_gate <= shreg;
                                    `SMCS_OFS_PATH_SEL: path_select_broadcast <= shreg;
                                    `SMCS_OFS_PIN_OVR: pin_override_ctrl <= shreg;
                                    default: soft_reset_ctrl <= soft_reset_ctrl;
                                endcase
                            end
                        end
                    endcase
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    if (phase == PH_ADDR && rd_mode)
                    begin
                        state <= ST_TX;
                        shreg <= {rd_data[6:0], 1'b0};
                        sda_oe <= ~rd_data[7];
                    end
                    else
                    begin
                        state <= ST_RX;
                        sda_oe <= 1'b0;
                        // a single data byte per write; extras go unacknowledged
                        phase <= (phase == PH_ADDR) ? PH_REG :
                                 (phase == PH_REG) ? PH_DATA : PH_DROP;
                    end
                end
            end
            ST_TX:
            begin
                if (scl_fall)
                begin
                    if (bit_cnt == 4'h7)
                    begin
                        // release for the host's nack, then wait for stop
                        sda_oe <= 1'b0;
                        state <= ST_RX;
                        phase <= PH_DROP;
                        bit_cnt <= 4'h8;
                    end
                    else
                    begin
                        sda_oe <= ~shreg[7];
                        shreg <= {shreg[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
            end
            default: sda_oe <= 1'b0;
        endcase
    end
end

// ==========================================================
// lane control outputs
reg next_lane_zero_side_pick;
reg next_lane_one_side_pick;
reg next_fan;

always @*
begin
    next_lane_zero_side_pick = (mode_s && pin_override_ctrl[`SMCS_BIT_OVR_SEL]) ?
                path_select_broadcast[`SMCS_BIT_LANE_ZERO_SIDE_PICK] : lane_zero_side_pick_pin_s;
    next_lane_one_side_pick = (mode_s && pin_override_ctrl[`SMCS_BIT_OVR_SEL]) ?
                path_select_broadcast[`SMCS_BIT_LANE_ONE_SIDE_PICK] : lane_one_side_pick_pin_s;
    next_fan = (mode_s && pin_override_ctrl[`SMCS_BIT_OVR_DUAL_OUTPUT_BROADCAST]) ?
               path_select_broadcast[`SMCS_BIT_DUAL_OUTPUT_BROADCAST] : fan_pin_s;
end

wire [7:0] sleep_eff = (mode_s && power_down_gate[`SMCS_BIT_PDN_ENABLE]) ?
                       lane_power_down : 8'h00;

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        lane_sleep <= 8'h00;
        lane_zero_side_pick <= 1'b0;
        lane_one_side_pick <= 1'b0;
        dual_output_broadcast <= 1'b0;
        lane_zero_a_output_mute <= 1'b1;
        lane_zero_b_output_mute <= 1'b0;
        lane_one_a_output_mute <= 1'b1;
        lane_one_b_output_mute <= 1'b0;
        idle_pin_blocked <= 1'b0;
        rate_pin_blocked <= 1'b0;
    end
    else
    begin
        lane_sleep <= sleep_eff;
        lane_zero_side_pick <= next_lane_zero_side_pick;
        lane_one_side_pick <= next_lane_one_side_pick;
        dual_output_broadcast <= next_fan;
        lane_zero_a_output_mute <= (~next_fan & ~next_lane_zero_side_pick) | sleep_eff[`SMCS_BIT_PDN_LANE_ZERO_A_OUTPUT];
        lane_zero_b_output_mute <= (~next_fan & next_lane_zero_side_pick) | sleep_eff[`SMCS_BIT_PDN_LANE_ZERO_B_OUTPUT];
        lane_one_a_output_mute <= (~next_fan & ~next_lane_one_side_pick) | sleep_eff[`SMCS_BIT_PDN_LANE_ONE_A_OUTPUT];
        lane_one_b_output_mute <= (~next_fan & next_lane_one_side_pick) | sleep_eff[`SMCS_BIT_PDN_SOB1];
        idle_pin_blocked <= mode_s & pin_override_ctrl[`SMCS_BIT_OVR_IDLE];
        rate_pin_blocked <= mode_s & pin_override_ctrl[`SMCS_BIT_OVR_RATE];
    end
end

endmodule

`default_nettype wire

// ==== verif/smcs_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// serial host; data is open drain, 1 = released to the pull-up
module smcs_host_model (
    input wire logic clk,
    input wire logic sda_w,
    output var logic scl,
    output var logic sda_drv
);
    // clock halves in clk cycles; 6 + 2 gives the 400 ns period
    int t_low = 6;
    int t_high = 2;
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // data moves only mid-way through the low half
    task automatic bit_io(input logic d, output logic q);
        scl <= 1'b0;
        wt(t_low / 2);
        sda_drv <= d;
        wt(t_low - t_low / 2);
        scl <= 1'b1;
        wt(t_high);
        q = sda_w;
    endtask
    // also serves as repeated start
    task automatic start();
        scl <= 1'b0;
        wt(3);
        sda_drv <= 1'b1;
        wt(3);
        scl <= 1'b1;
        wt(4);
        sda_drv <= 1'b0;
        wt(4);
    endtask
    task automatic stop();
        scl <= 1'b0;
        wt(3);
        sda_drv <= 1'b0;
        wt(3);
        scl <= 1'b1;
        wt(4);
        sda_drv <= 1'b1;
        wt(2);
    endtask
    task automatic tx(input logic [7:0] b, output logic nak);
        logic q;
        for (int i = 7; i >= 0; i--) bit_io(b[i], q);
        bit_io(1'b1, nak);
    endtask
    // ends a read with the given acknowledge level
    task automatic rx(input logic nak, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(nak, q);
    endtask
endmodule
`default_nettype wire

// ==== verif/smcs_config_slave_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// link and lane-control checks
module smcs_config_slave_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serial_mgmt_mode_pin,
    input wire logic serial_mgmt_clock,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic pin_lane_zero_side_pick,
    input wire logic bus_idle,
    input wire logic [7:0] lane_sleep,
    input wire logic lane_zero_side_pick,
    input wire logic lane_one_side_pick,
    input wire logic dual_output_broadcast,
    input wire logic lane_zero_a_output_mute,
    input wire logic lane_zero_b_output_mute,
    input wire logic lane_one_a_output_mute,
    input wire logic lane_one_b_output_mute,
    input wire logic idle_pin_blocked,
    input wire logic rate_pin_blocked
);
    wire mode = serial_mgmt_mode_pin;
    wire scl = serial_mgmt_clock;
    wire quiet = lane_sleep == 8'h00;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence start_seq;
        (mode && scl && sda_in) [*4] ##1 (scl && !sda_in);
    endsequence
    sequence stop_seq;
        (mode && scl && !sda_in) [*4] ##1 (mode && scl && sda_in);
    endsequence
    a_start_busy: assert property (start_seq |-> ##[1:8] !bus_idle)
        else $error("start did not clear idle");
    a_idle_not_early: assert property (stop_seq |-> !bus_idle [*8])
        else $error("idle too soon after stop");
    a_idle_after_free: assert property (stop_seq |-> ##[1:130] bus_idle)
        else $error("idle missing after stop");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("data moved with clock high");
    a_oe_stands: assert property ($rose(sda_oe) |-> sda_oe [*3])
        else $error("acknowledge too short");
    a_open_drain: assert property (!sda_out)
        else $error("data driven high");
    a_quiet_no_mode: assert property (!mode [*8] |-> !sda_oe && quiet && !idle_pin_blocked
        && !rate_pin_blocked)
        else $error("active without mode");
    a_pins_govern: assert property ((!mode && $stable(pin_lane_zero_side_pick)) [*8]
        |-> lane_zero_side_pick == pin_lane_zero_side_pick)
        else $error("pin did not govern");
    a_both_driven: assert property ((dual_output_broadcast && quiet) [*2]
        |-> !(lane_zero_a_output_mute || lane_zero_b_output_mute
        || lane_one_a_output_mute || lane_one_b_output_mute))
        else $error("output muted in broadcast");
    a_unpicked_mute: assert property ((!dual_output_broadcast && quiet
        && $stable({lane_zero_side_pick, lane_one_side_pick})) [*2]
        |-> lane_zero_a_output_mute == !lane_zero_side_pick
        && lane_zero_b_output_mute == lane_zero_side_pick
        && lane_one_a_output_mute == !lane_one_side_pick
        && lane_one_b_output_mute == lane_one_side_pick)
        else $error("wrong side muted");
endmodule
bind smcs_config_slave smcs_config_slave_asserts u_chk (
    .clk, .reset_n, .serial_mgmt_mode_pin, .serial_mgmt_clock, .sda_in, .sda_out, .sda_oe,
    .pin_lane_zero_side_pick, .bus_idle, .lane_sleep, .lane_zero_side_pick,
    .lane_one_side_pick, .dual_output_broadcast, .lane_zero_a_output_mute,
    .lane_zero_b_output_mute, .lane_one_a_output_mute, .lane_one_b_output_mute,
    .idle_pin_blocked, .rate_pin_blocked
);
`default_nettype wire

// ==== verif/smcs_config_slave_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "smcs_defs.vh"
// ==========================================
module smcs_config_slave_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic mode = 1'b0;
    logic [3:0] strap = 4'h0;
    logic [2:0] pin = 3'h0;
    logic [7:0] dev = {`SMCS_ADDR_BASE, 1'b0};
    logic [7:0] ofs [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h05};
    wire scl, sda_drv, sda_w, oe, idle;
    wire [7:0] sleep;
    wire [2:0] eff;
    wire [3:0] mute;
    wire [1:0] blk;
    int fail_count = 0;
    int total_checks = 0;
    // the pull-up wins unless someone pulls low
    assign sda_w = sda_drv & ~oe;
    initial
    begin
        forever #25 clk = ~clk;
    end
    smcs_config_slave u_dut (
        .clk(clk), .reset_n(reset_n), .serial_mgmt_mode_pin(mode), .serial_mgmt_clock(scl),
        .sda_in(sda_w), .sda_out(), .sda_oe(oe), .addr_strap(strap),
        .pin_lane_zero_side_pick(pin[2]), .pin_lane_one_side_pick(pin[1]),
        .pin_dual_output_broadcast(pin[0]), .bus_idle(idle), .lane_sleep(sleep),
        .lane_zero_side_pick(eff[2]), .lane_one_side_pick(eff[1]),
        .dual_output_broadcast(eff[0]), .lane_zero_a_output_mute(mute[3]),
        .lane_zero_b_output_mute(mute[2]), .lane_one_a_output_mute(mute[1]),
        .lane_one_b_output_mute(mute[0]), .idle_pin_blocked(blk[1]), .rate_pin_blocked(blk[0])
    );
    smcs_host_model u_host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_drv(sda_drv));
    // ==========================================
    task give_verdict();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [23:0] g, input logic [23:0] e);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // output order: sleep, picks and broadcast, mutes a0 b0 a1 b1, blocked
    task outs(input logic [16:0] e);
        wt(3);
        chk({7'h00, sleep, eff, mute, blk}, {7'h00, e});
    endtask
    task wait_idle();
        int n;
        n = 0;
        while (idle !== 1'b1 && n < 300)
        begin
            wt(1);
            n++;
        end
        if (n >= 300)
        begin
            fail_count++;
            $display("Error at %0t: bus never idle", $time);
            give_verdict();
        end
        chk({23'h000000, n > 80}, 24'h000001);
    endtask
    task wr(input logic [7:0] r, input logic [7:0] d);
        logic [2:0] k;
        u_host.start();
        u_host.tx(dev, k[2]);
        u_host.tx(r, k[1]);
        u_host.tx(d, k[0]);
        u_host.stop();
        chk({21'h000000, k}, 24'h000000);
        wait_idle();
    endtask
    task rd(input logic [7:0] r, input logic [7:0] e);
        logic [2:0] k;
        logic [7:0] d;
        u_host.start();
        u_host.tx(dev, k[2]);
        u_host.tx(r, k[1]);
        u_host.start();
        u_host.tx(dev | 8'h01, k[0]);
        u_host.rx(1'b1, d);
        u_host.stop();
        chk({13'h0000, k, d}, {16'h0000, e});
        wait_idle();
    endtask
    // ==========================================
    task t_reset();
        outs({8'h00, 3'h0, 4'hA, 2'h0});
        mode <= 1'b1;
        wt(8);
        wr(8'h00, 8'h01);
        wr(8'h18, 8'h88);
        wr(8'h17, 8'h0F);
        rd(8'h18, 8'h00);
        for (int i = 0; i < 6; i++) rd(ofs[i], 8'h00);
    endtask
    task t_regs();
        wr(8'h01, 8'hA5);
        rd(8'h01, 8'hA5);
        outs({8'h00, 3'h0, 4'hA, 2'h0});
        wr(8'h02, 8'h01);
        outs({8'hA5, 3'h0, 4'hF, 2'h0});
        wr(8'h08, 8'h17);
        wr(8'h03, 8'h06);
        outs({8'hA5, 3'h6, 4'h5, 2'h3});
        wr(8'h03, 8'h01);
        outs({8'hA5, 3'h1, 4'h5, 2'h3});
        wr(8'h02, 8'h00);
        outs({8'h00, 3'h1, 4'h0, 2'h3});
    endtask
    task t_soft();
        wr(8'h00, 8'h01);
        for (int i = 0; i < 5; i++) rd(ofs[i], 8'h00);
        outs({8'h00, 3'h0, 4'hA, 2'h0});
    endtask
    task t_pins();
        pin <= 3'h7;
        wt(8);
        outs({8'h00, 3'h7, 4'h0, 2'h0});
        wr(8'h08, 8'h02);
        outs({8'h00, 3'h1, 4'h0, 2'h0});
        mode <= 1'b0;
        wt(8);
        outs({8'h00, 3'h7, 4'h0, 2'h0});
        pin <= 3'h0;
        mode <= 1'b1;
        wt(8);
        wr(8'h00, 8'h01);
    endtask
    task t_addr();
        logic [2:0] k;
        strap <= 4'h5;
        dev <= {`SMCS_ADDR_BASE, 1'b0} | {3'h0, 4'h5, 1'b0};
        wt(8);
        u_host.start();
        u_host.tx({`SMCS_ADDR_BASE, 1'b0}, k[2]);
        u_host.tx(8'h01, k[1]);
        u_host.tx(8'h33, k[0]);
        u_host.stop();
        chk({21'h000000, k}, 24'h000007);
        wait_idle();
        rd(8'h01, 8'h00);
        strap <= 4'h0;
        dev <= {`SMCS_ADDR_BASE, 1'b0};
        wt(8);
    endtask
    task t_mode();
        logic k;
        mode <= 1'b0;
        wt(8);
        u_host.start();
        u_host.tx(dev, k);
        u_host.stop();
        chk({23'h000000, k}, 24'h000001);
        wt(120);
        mode <= 1'b1;
        wt(8);
    endtask
    // slow host: long clock halves
    task t_slow();
        u_host.t_low = 10;
        u_host.t_high = 10;
        wr(8'h03, 8'h06);
        rd(8'h03, 8'h06);
        u_host.t_low = 6;
        u_host.t_high = 2;
    endtask
    initial
    begin
        wt(12);
        reset_n <= 1'b1;
        wt(8);
        t_reset();
        t_regs();
        t_soft();
        t_pins();
        t_addr();
        t_mode();
        t_slow();
        give_verdict();
    end
endmodule
`default_nettype wire
